// ---- slbc_pkg.sv ----
package slbc_pkg;

    // clock figures in MHz
    localparam int MCLK_FREQ_MHZ = 100;
    localparam int OSC_FREQ_MHZ  = 33;

    // half an oscillator period in mclk cycles, rounded down, at least one
    localparam int         OSC_HALF_RAW = MCLK_FREQ_MHZ / (2 * OSC_FREQ_MHZ);
    localparam logic [3:0] OSC_HALF_CYC = (OSC_HALF_RAW < 1) ? 4'h1 : 4'(OSC_HALF_RAW);
    localparam logic [7:0] OSC_STEP     = 8'(OSC_FREQ_MHZ);
    localparam logic [7:0] OSC_WRAP     = 8'(MCLK_FREQ_MHZ);

    // received frame: bit 0 is not checked, bits 1..35 must match the pattern
    localparam int          PAYLOAD_W        = 36;
    localparam logic [35:0] CHECK_MASK       = 36'hF_FFFF_FFFE;
    localparam logic [35:0] EXPECTED_PATTERN = 36'h0_0000_0000;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LINK_DETECT = 8'h0C;
    localparam logic [7:0] IDX_FWD_ERR     = 8'h25;
    localparam logic [7:0] IDX_CTRL        = 8'h30;
    localparam logic [7:0] IDX_CRC_FUNC    = 8'h31;
    localparam logic [7:0] IDX_CRC_TEST    = 8'h32;
    localparam logic [7:0] IDX_IRQ_STAT    = 8'h33;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h34;
    localparam logic [7:0] IDX_STATUS      = 8'h35;

    // control register bits
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_OSC_BIT = 1;
    localparam int CTRL_CLR_BIT = 2;

    // link detect bit
    localparam int LINK_DETECT_BIT = 0;

    // status register bits
    localparam int ST_CHECK_BIT  = 0;
    localparam int ST_RESULT_BIT = 1;
    localparam int ST_LOCK_BIT   = 2;
    localparam int ST_REMOTE_BIT = 3;
    localparam int ST_OSC_BIT    = 4;
    localparam int ST_ACTIVE_BIT = 5;

    // interrupt bits
    localparam int         IRQ_W        = 4;
    localparam int         IRQ_DONE     = 0;
    localparam int         IRQ_FWD_ERR  = 1;
    localparam int         IRQ_CRC_ERR  = 2;
    localparam int         IRQ_LOCKLOSS = 3;
    localparam logic [3:0] IRQ_NONE     = 4'h0;

    localparam logic [7:0]  CNT_ZERO  = 8'h00;
    localparam logic [7:0]  CNT_MAX   = 8'hFF;
    localparam logic [7:0]  CNT_ONE   = 8'h01;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REQUEST,
        ST_WAIT_LOCK,
        ST_CHECK,
        ST_DONE
    } slbc_fsm_t;

    // everything that arrives from outside the mclk domain
    typedef struct packed {
        logic                 link_clk;
        logic                 selftest_enable;
        logic                 clock_select;
        logic                 powerdown;
        logic                 link_lock;
        logic                 bc_lock;
        logic                 remote_selftest;
        logic                 remote_awake;
        logic                 bc_crc_err_toggle;
        logic [PAYLOAD_W-1:0] payload;
    } slbc_pins_t;

    typedef struct packed {
        slbc_pins_t stage1;
        slbc_pins_t stage2;
    } slbc_sync_state_t;

    typedef struct packed {
        slbc_fsm_t       fsm;
        logic            result;
        logic            any_err;
        logic            pulse_active;
        logic [3:0]      pulse_cnt;
        logic            pass;
        logic [7:0]      fwd_cnt;
        logic [7:0]      crc_func;
        logic [7:0]      crc_test;
        logic            ctrl_en;
        logic            ctrl_osc;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic            ack;
        logic [31:0]     rdata;
        logic [7:0]      osc_acc;
        logic            lclk_d;
        logic            remote_d;
        logic            lock_d;
        logic            crc_tgl_d;
        logic            bc_req;
        logic            wake;
        logic            lock_out;
        logic            osc_sel;
        logic            checking;
        logic            normal_mode;
    } slbc_state_t;

endpackage

// ---- slbc_sync.sv ----
`timescale 1ns/1ps
module slbc_sync (
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                clk_en,
    input  wire slbc_pkg::slbc_pins_t pins_async,
    output      slbc_pkg::slbc_pins_t pins_sync
);

    slbc_pkg::slbc_sync_state_t r_reg;
    slbc_pkg::slbc_sync_state_t r_next;

    // two stages; only stage2 leaves this module
    always_comb begin
        r_next        = r_reg;
        r_next.stage1 = pins_async;
        r_next.stage2 = r_reg.stage1;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            r_reg <= '0;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    assign pins_sync = r_reg.stage2;

endmodule // slbc_sync

// ---- slbc_frame_check.sv ----
`timescale 1ns/1ps
module slbc_frame_check (
    input  wire logic [slbc_pkg::PAYLOAD_W-1:0] payload,
    output      logic                          frame_err
);

    logic [slbc_pkg::PAYLOAD_W-1:0] diff;

    // any mismatch among the checked bits flags the frame once
    always_comb begin
        diff      = (payload ^ slbc_pkg::EXPECTED_PATTERN) & slbc_pkg::CHECK_MASK;
        frame_err = |diff;
    end

endmodule // slbc_frame_check

// ---- slbc_checker.sv ----
`timescale 1ns/1ps
module slbc_checker (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    input  wire logic                          clk_en,
    input  wire logic                          link_clk,
    input  wire logic [slbc_pkg::PAYLOAD_W-1:0] rx_payload,
    input  wire logic                          link_lock,
    input  wire logic                          selftest_enable_pin,
    input  wire logic                          selftest_clock_select_pin,
    input  wire logic                          powerdown,
    input  wire logic                          bc_lock,
    input  wire logic                          remote_selftest,
    input  wire logic                          remote_awake,
    input  wire logic                          bc_crc_err_toggle,
    input  wire logic [9:0]                    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output      logic [31:0]                   avs_readdata,
    output      logic                          avs_waitrequest,
    output      logic                          selftest_pass,
    output      logic                          lock_out,
    output      logic                          bc_selftest_req,
    output      logic                          bc_wake,
    output      logic                          osc_select,
    output      logic                          checking,
    output      logic                          link_normal_mode,
    output      logic                          irq
);

    localparam slbc_pkg::slbc_state_t RESET_STATE = '{
        fsm:          slbc_pkg::ST_IDLE,
        result:       1'b0,
        any_err:      1'b0,
        pulse_active: 1'b0,
        pulse_cnt:    4'h0,
        pass:         1'b0,
        fwd_cnt:      slbc_pkg::CNT_ZERO,
        crc_func:     slbc_pkg::CNT_ZERO,
        crc_test:     slbc_pkg::CNT_ZERO,
        ctrl_en:      1'b0,
        ctrl_osc:     1'b0,
        irq_stat:     slbc_pkg::IRQ_NONE,
        irq_mask:     slbc_pkg::IRQ_NONE,
        ack:          1'b0,
        rdata:        slbc_pkg::DATA_ZERO,
        osc_acc:      slbc_pkg::CNT_ZERO,
        lclk_d:       1'b0,
        remote_d:     1'b0,
        lock_d:       1'b0,
        crc_tgl_d:    1'b0,
        bc_req:       1'b0,
        wake:         1'b0,
        lock_out:     1'b0,
        osc_sel:      1'b0,
        checking:     1'b0,
        normal_mode:  1'b1
    };

    slbc_pkg::slbc_state_t r_reg;
    slbc_pkg::slbc_state_t r_next;
    slbc_pkg::slbc_pins_t  pins_async;
    slbc_pkg::slbc_pins_t  s;
    logic                  frame_err;

    function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
        reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic inc);
        sat_inc = (inc && (v != slbc_pkg::CNT_MAX)) ? v + slbc_pkg::CNT_ONE : v;
    endfunction

    always_comb begin
        pins_async                   = '0;
        pins_async.link_clk          = link_clk;
        pins_async.selftest_enable   = selftest_enable_pin;
        pins_async.clock_select      = selftest_clock_select_pin;
        pins_async.powerdown         = powerdown;
        pins_async.link_lock         = link_lock;
        pins_async.bc_lock           = bc_lock;
        pins_async.remote_selftest   = remote_selftest;
        pins_async.remote_awake      = remote_awake;
        pins_async.bc_crc_err_toggle = bc_crc_err_toggle;
        pins_async.payload           = rx_payload;
    end

    slbc_sync u_sync (
        .mclk       (mclk),
        .resetn     (resetn),
        .clk_en     (clk_en),
        .pins_async (pins_async),
        .pins_sync  (s)
    );

    slbc_frame_check u_check (
        .payload   (s.payload),
        .frame_err (frame_err)
    );

    logic             en_req;
    logic             osc_sel;
    logic             osc_tick;
    logic [8:0]       osc_sum;
    logic             lclk_rise;
    logic             lclk_fall;
    logic             frame_stb;
    logic             pulse_end;
    logic             remote_enter;
    logic             bc_err_evt;
    logic             lock_lost;
    logic             test_done;
    logic             fwd_evt;
    logic             crc_evt;
    logic             acc_write;
    logic             clr_cnt;
    localparam int    IRQ_W_L = slbc_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irq_set;

    always_comb begin
        r_next = r_reg;

        en_req  = s.selftest_enable | r_reg.ctrl_en;
        osc_sel = s.clock_select | r_reg.ctrl_osc;

        // oscillator time base as a phase accumulator on mclk
        osc_sum  = {1'b0, r_reg.osc_acc} + {1'b0, slbc_pkg::OSC_STEP};
        osc_tick = (osc_sum >= {1'b0, slbc_pkg::OSC_WRAP});
        r_next.osc_acc = osc_tick ? 8'(osc_sum - {1'b0, slbc_pkg::OSC_WRAP}) : osc_sum[7:0];

        // link clock edges from the synchronised sample
        lclk_rise      = s.link_clk & ~r_reg.lclk_d;
        lclk_fall      = ~s.link_clk & r_reg.lclk_d;
        r_next.lclk_d  = s.link_clk;

        // frames are taken mid-period, one per clock period of the chosen source
        frame_stb = osc_sel ? osc_tick : lclk_fall;
        pulse_end = osc_sel ? (r_reg.pulse_cnt <= 4'h1) : lclk_rise;

        remote_enter    = s.remote_selftest & ~r_reg.remote_d;
        r_next.remote_d = s.remote_selftest;
        bc_err_evt       = s.bc_crc_err_toggle ^ r_reg.crc_tgl_d;
        r_next.crc_tgl_d = s.bc_crc_err_toggle;
        lock_lost        = r_reg.lock_d & ~s.link_lock;
        r_next.lock_d    = s.link_lock;

        test_done = 1'b0;
        fwd_evt   = 1'b0;
        crc_evt   = 1'b0;

        // self-test sequence
        unique case (r_reg.fsm)
            slbc_pkg::ST_IDLE,
            slbc_pkg::ST_DONE: begin
                if (en_req) begin
                    r_next.fsm          = slbc_pkg::ST_REQUEST;
                    r_next.result       = 1'b0;
                    r_next.any_err      = 1'b0;
                    r_next.fwd_cnt      = slbc_pkg::CNT_ZERO;
                    r_next.pulse_active = 1'b0;
                end
            end
            slbc_pkg::ST_REQUEST: begin
                if (!en_req) begin
                    r_next.fsm = slbc_pkg::ST_DONE;
                    test_done  = 1'b1;
                end else if (s.remote_selftest) begin
                    r_next.fsm = slbc_pkg::ST_WAIT_LOCK;
                end
            end
            slbc_pkg::ST_WAIT_LOCK: begin
                if (!en_req) begin
                    r_next.fsm = slbc_pkg::ST_DONE;
                    test_done  = 1'b1;
                end else if (s.link_lock && s.remote_selftest) begin
                    r_next.fsm    = slbc_pkg::ST_CHECK;
                    r_next.result = 1'b1;
                end
            end
            slbc_pkg::ST_CHECK: begin
                if (!en_req) begin
                    r_next.fsm          = slbc_pkg::ST_DONE;
                    r_next.result       = ~r_reg.any_err;
                    r_next.pulse_active = 1'b0;
                    test_done           = 1'b1;
                end else if (frame_stb && s.link_lock && frame_err) begin
                    r_next.any_err      = 1'b1;
                    r_next.fwd_cnt      = sat_inc(r_reg.fwd_cnt, 1'b1);
                    r_next.pulse_active = 1'b1;
                    r_next.pulse_cnt    = slbc_pkg::OSC_HALF_CYC;
                    fwd_evt             = 1'b1;
                end else if (r_reg.pulse_active) begin
                    if (pulse_end) begin
                        r_next.pulse_active = 1'b0;
                    end
                    r_next.pulse_cnt = r_reg.pulse_cnt - 4'h1;
                end
            end
            default: begin
                r_next.fsm = slbc_pkg::ST_IDLE;
            end
        endcase

        // power-down ends any test and clears the held result
        if (s.powerdown) begin
            r_next.fsm          = slbc_pkg::ST_IDLE;
            r_next.result       = 1'b0;
            r_next.pulse_active = 1'b0;
            r_next.any_err      = 1'b0;
        end

        // result pin: high in the check phase except error pulses, then the held verdict
        r_next.pass = (r_next.fsm == slbc_pkg::ST_CHECK) ? ~r_next.pulse_active : r_next.result;

        r_next.bc_req = (r_next.fsm == slbc_pkg::ST_REQUEST) ||
                        (r_next.fsm == slbc_pkg::ST_WAIT_LOCK) ||
                        (r_next.fsm == slbc_pkg::ST_CHECK);
        r_next.wake        = (r_next.fsm == slbc_pkg::ST_REQUEST) & ~s.remote_awake;
        r_next.checking    = (r_next.fsm == slbc_pkg::ST_CHECK);
        r_next.normal_mode = ~r_next.bc_req;
        r_next.lock_out    = s.link_lock;
        r_next.osc_sel     = osc_sel;

        // bus access completes on the second edge of the request
        acc_write  = avs_write & r_reg.ack & avs_byteenable[0];
        r_next.ack = (avs_read | avs_write) & ~r_reg.ack;
        clr_cnt    = acc_write && reg_hit(avs_address, slbc_pkg::IDX_CTRL) &&
                     avs_writedata[slbc_pkg::CTRL_CLR_BIT];

        // back-channel error counters; an error in the clearing cycle still counts
        crc_evt = bc_err_evt & s.bc_lock;
        if (remote_enter || clr_cnt) begin
            r_next.crc_func = sat_inc(slbc_pkg::CNT_ZERO, crc_evt);
            r_next.crc_test = sat_inc(slbc_pkg::CNT_ZERO, crc_evt & s.remote_selftest);
        end else begin
            r_next.crc_func = sat_inc(r_reg.crc_func, crc_evt);
            r_next.crc_test = sat_inc(r_reg.crc_test, crc_evt & s.remote_selftest);
        end

        // register writes
        if (acc_write) begin
            if (reg_hit(avs_address, slbc_pkg::IDX_CTRL)) begin
                r_next.ctrl_en  = avs_writedata[slbc_pkg::CTRL_EN_BIT];
                r_next.ctrl_osc = avs_writedata[slbc_pkg::CTRL_OSC_BIT];
            end
            if (reg_hit(avs_address, slbc_pkg::IDX_IRQ_MASK)) begin
                r_next.irq_mask = avs_writedata[IRQ_W_L-1:0];
            end
        end

        // sticky events; a set in the clearing cycle wins
        irq_set                            = slbc_pkg::IRQ_NONE;
        irq_set[slbc_pkg::IRQ_DONE]        = test_done;
        irq_set[slbc_pkg::IRQ_FWD_ERR]     = fwd_evt;
        irq_set[slbc_pkg::IRQ_CRC_ERR]     = crc_evt;
        irq_set[slbc_pkg::IRQ_LOCKLOSS]    = lock_lost & (r_reg.fsm == slbc_pkg::ST_CHECK);
        r_next.irq_stat = r_reg.irq_stat;
        if (acc_write && reg_hit(avs_address, slbc_pkg::IDX_IRQ_STAT)) begin
            r_next.irq_stat = r_reg.irq_stat & ~avs_writedata[IRQ_W_L-1:0];
        end
        r_next.irq_stat = r_next.irq_stat | irq_set;

        // read data is captured on the first edge and shown while waitrequest is low
        if (avs_read && !r_reg.ack) begin
            r_next.rdata = slbc_pkg::DATA_ZERO;
            if (reg_hit(avs_address, slbc_pkg::IDX_LINK_DETECT)) begin
                r_next.rdata[slbc_pkg::LINK_DETECT_BIT] = s.bc_lock;
            end
            if (reg_hit(avs_address, slbc_pkg::IDX_FWD_ERR)) begin
                r_next.rdata[7:0] = r_reg.fwd_cnt;
            end
            if (reg_hit(avs_address, slbc_pkg::IDX_CTRL)) begin
                r_next.rdata[slbc_pkg::CTRL_EN_BIT]  = r_reg.ctrl_en;
                r_next.rdata[slbc_pkg::CTRL_OSC_BIT] = r_reg.ctrl_osc;
            end
            if (reg_hit(avs_address, slbc_pkg::IDX_CRC_FUNC)) begin
                r_next.rdata[7:0] = r_reg.crc_func;
            end
            if (reg_hit(avs_address, slbc_pkg::IDX_CRC_TEST)) begin
                r_next.rdata[7:0] = r_reg.crc_test;
            end
            if (reg_hit(avs_address, slbc_pkg::IDX_IRQ_STAT)) begin
                r_next.rdata[IRQ_W_L-1:0] = r_reg.irq_stat;
            end
            if (reg_hit(avs_address, slbc_pkg::IDX_IRQ_MASK)) begin
                r_next.rdata[IRQ_W_L-1:0] = r_reg.irq_mask;
            end
            if (reg_hit(avs_address, slbc_pkg::IDX_STATUS)) begin
                r_next.rdata[slbc_pkg::ST_CHECK_BIT]  = r_reg.checking;
                r_next.rdata[slbc_pkg::ST_RESULT_BIT] = r_reg.pass;
                r_next.rdata[slbc_pkg::ST_LOCK_BIT]   = r_reg.lock_out;
                r_next.rdata[slbc_pkg::ST_REMOTE_BIT] = s.remote_selftest;
                r_next.rdata[slbc_pkg::ST_OSC_BIT]    = r_reg.osc_sel;
                r_next.rdata[slbc_pkg::ST_ACTIVE_BIT] = r_reg.bc_req;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            r_reg <= RESET_STATE;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    assign avs_waitrequest  = (avs_read | avs_write) & ~r_reg.ack;
    assign avs_readdata     = r_reg.rdata;
    assign selftest_pass    = r_reg.pass;
    assign lock_out         = r_reg.lock_out;
    assign bc_selftest_req  = r_reg.bc_req;
    assign bc_wake          = r_reg.wake;
    assign osc_select       = r_reg.osc_sel;
    assign checking         = r_reg.checking;
    assign link_normal_mode = r_reg.normal_mode;
    assign irq              = |(r_reg.irq_stat & r_reg.irq_mask);

endmodule // slbc_checker

// ---- slbc_props.sv ----
`timescale 1ns/1ps
module slbc_props (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic link_lock,
    input wire logic selftest_enable_pin,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic selftest_pass,
    input wire logic lock_out,
    input wire logic bc_selftest_req,
    input wire logic bc_wake,
    input wire logic checking,
    input wire logic link_normal_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    bus_answer_a: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not on second edge");
    start_req_a: assert property ($rose(selftest_enable_pin) |-> ##[1:8] bc_selftest_req)
        else $error("enable pin raised no request");
    check_req_a: assert property (checking |-> bc_selftest_req && !link_normal_mode)
        else $error("checking without request");
    wake_req_a: assert property (bc_wake |-> bc_selftest_req)
        else $error("wake outside request");
    pass_rise_a: assert property ($rose(selftest_pass) |-> checking)
        else $error("result rose outside checking");
    pulse_len_a: assert property ($fell(selftest_pass) && checking |-> ##[1:8] (selftest_pass || !checking))
        else $error("error pulse too long");
    stop_check_a: assert property ($fell(bc_selftest_req) |-> !checking && link_normal_mode)
        else $error("checking went on after stop");
    lock_follow_a: assert property ($stable({resetn, link_lock})[*5] |-> lock_out == link_lock)
        else $error("lock output does not follow lock");
endmodule // slbc_props
bind slbc_checker slbc_props i_props (.mclk(mclk), .resetn(resetn), .link_lock(link_lock),
    .selftest_enable_pin(selftest_enable_pin), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .selftest_pass(selftest_pass), .lock_out(lock_out),
    .bc_selftest_req(bc_selftest_req), .bc_wake(bc_wake), .checking(checking), .link_normal_mode(link_normal_mode));

// ---- slbc_ser_model.sv ----
`timescale 1ns/1ps
module slbc_ser_model (
    input  wire logic   bc_selftest_req,
    input  wire logic   bc_wake,
    output logic        remote_awake = 1'h0,
    output logic        remote_selftest = 1'h0,
    output logic        link_clk = 1'h0,
    output logic        bc_crc_err_toggle = 1'h0,
    output logic [35:0] rx_payload = 36'h0
);
    logic [35:0] pend = 36'h0;
    logic        want = 1'h0;
    always @(posedge bc_wake) remote_awake <= #200 1'h1;
    always @(bc_selftest_req or remote_awake) want <= #100 bc_selftest_req & remote_awake;
    // clock stands still outside test frames, payload then toggles
    // test mode follows the frame grid, so zeros stand as soon as it is shown
    always #40 begin
        remote_selftest = want;
        link_clk = remote_selftest & ~link_clk;
        if (!remote_selftest) rx_payload = ~rx_payload;
        else if (link_clk) rx_payload = pend;
        if (link_clk) pend = 36'h0;
    end
    task automatic send(input logic [35:0] w);
        pend = w;
    endtask
    task automatic crc_err();
        bc_crc_err_toggle <= ~bc_crc_err_toggle;
    endtask
endmodule // slbc_ser_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic        mclk = 1'h0, resetn = 1'h0, link_lock = 1'h0, pin_en = 1'h0, pin_cs = 1'h0, clk_en = 1'h1;
    logic        powerdown = 1'h0, bc_lock = 1'h0, avs_read = 1'h0, avs_write = 1'h0, pass_d = 1'h0;
    logic [9:0]  avs_address = 10'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        avs_waitrequest, selftest_pass, lock_out, bc_selftest_req, bc_wake, osc_select, checking;
    logic        link_normal_mode, irq, remote_awake, remote_selftest, link_clk, crc_tgl;
    logic [35:0] rx_payload;
    int          error_cnt = 0, n_tests = 0, falls = 0, nerr;
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        pass_d <= selftest_pass;
        if (checking && pass_d && !selftest_pass) falls <= falls + 1;
    end
    slbc_ser_model i_ser (.bc_selftest_req, .bc_wake, .remote_awake, .remote_selftest, .link_clk,
        .bc_crc_err_toggle(crc_tgl), .rx_payload);
    slbc_checker i_dut (.mclk, .resetn, .clk_en, .link_clk, .rx_payload, .link_lock,
        .selftest_enable_pin(pin_en), .selftest_clock_select_pin(pin_cs), .powerdown, .bc_lock,
        .remote_selftest, .remote_awake, .bc_crc_err_toggle(crc_tgl), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .selftest_pass, .lock_out,
        .bc_selftest_req, .bc_wake, .osc_select, .checking, .link_normal_mode, .irq);
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_up();
        error_cnt++;
        $display("ERROR %0t: wait ran out", $time);
        tally_and_finish();
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n = 0;
        avs_address <= {idx, 2'h0};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, wd};
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 50);
        if (n >= 50) give_up();
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [35:0] exp);
        bus(1'h0, idx, 8'h0);
        chk(rd, exp);
    endtask
    task automatic wait_on(input logic want);
        int n = 0;
        while (checking !== want && n < 400) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 400) give_up();
    endtask
    task automatic crc_hit();
        i_ser.crc_err();
        repeat (8) @(posedge mclk);
    endtask
    initial begin
        void'($urandom(25464));
        repeat (3) @(posedge mclk);
        resetn <= 1'h1;
        @(posedge mclk);
        rd_chk(slbc_pkg::IDX_FWD_ERR, 36'h0);
        rd_chk(slbc_pkg::IDX_LINK_DETECT, 36'h0);
        rd_chk(8'h01, 36'h0);
        bc_lock <= 1'h1;
        repeat (2) crc_hit();
        rd_chk(slbc_pkg::IDX_LINK_DETECT, 36'h1);
        rd_chk(slbc_pkg::IDX_CRC_FUNC, 36'h2);
        bus(1'h1, slbc_pkg::IDX_IRQ_MASK, 8'h01);
        link_lock <= 1'h1;
        pin_en <= 1'h1;
        wait_on(1'h1);
        chk(selftest_pass, 36'h1);
        rd_chk(slbc_pkg::IDX_CRC_FUNC, 36'h0);
        crc_hit();
        nerr = 1 + $urandom % 4;
        // last frame carries only the unchecked bit
        for (int i = 0; i <= nerr; i++) begin
            i_ser.send(i == nerr ? 36'h1 : 36'h2 << ($urandom % 35) | 36'({$urandom, $urandom}) & 36'hF_FFFF_FFFE);
            repeat (30) @(posedge mclk);
        end
        chk(falls, nerr);
        pin_en <= 1'h0;
        wait_on(1'h0);
        chk({selftest_pass, link_normal_mode, irq}, 36'h3);
        rd_chk(slbc_pkg::IDX_FWD_ERR, nerr);
        bus(1'h1, slbc_pkg::IDX_IRQ_STAT, 8'h0F);
        chk(irq, 36'h0);
        repeat (20) @(posedge mclk);
        crc_hit();
        rd_chk(slbc_pkg::IDX_CRC_TEST, 36'h1);
        rd_chk(slbc_pkg::IDX_CRC_FUNC, 36'h2);
        pin_cs <= 1'h1;
        bus(1'h1, slbc_pkg::IDX_CTRL, 8'h01);
        wait_on(1'h1);
        chk(osc_select, 36'h1);
        repeat (50) @(posedge mclk);
        bus(1'h1, slbc_pkg::IDX_CTRL, 8'h00);
        wait_on(1'h0);
        chk(selftest_pass, 36'h1);
        rd_chk(slbc_pkg::IDX_FWD_ERR, 36'h0);
        rd_chk(slbc_pkg::IDX_CRC_TEST, 36'h0);
        // frozen by the clock enable, power-down must not reach the held result yet
        clk_en <= 1'h0;
        powerdown <= 1'h1;
        repeat (6) @(posedge mclk);
        chk(selftest_pass, 36'h1);
        clk_en <= 1'h1;
        repeat (6) @(posedge mclk);
        chk(selftest_pass, 36'h0);
        powerdown <= 1'h0;
        crc_hit();
        bus(1'h1, slbc_pkg::IDX_CTRL, 8'h04);
        rd_chk(slbc_pkg::IDX_CRC_FUNC, 36'h0);
        tally_and_finish();
    end
endmodule // testbench
